// file: logic/ppd_power_ctrl.v
// Power-mode, management and status lamp controller for a single-port PHY
// Assumes pins arrive unsynchronised; SYS_RST mirrors the chip reset pin
`timescale 1ns/100ps
`default_nettype none
`include "ppd_power_map.vh"
module ppd_power_ctrl
#(
  parameter [31:0] SILENCE_CYC = `PPD_SILENCE_CYC,
  parameter [31:0] PULSE_CYC = `PPD_PULSE_CYC,
  parameter [31:0] REFRESH_CYC = `PPD_REFRESH_CYC,
  parameter [31:0] BLINK_CYC = `PPD_BLINK_CYC
)
(
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // Management pins
  input wire MDC,
  input wire MDIO_I,
  output reg MDIO_O,
  output reg MDIO_OE,
  // Straps and lamp pin
  input wire STRAP_SOFT_PD,
  input wire STRAP_SLEEP,
  input wire STRAP_EEE,
  input wire LAMP_I,
  output reg LAMP_O,
  output reg LAMP_OE,
  // Line and link status
  input wire LINE_ENERGY,
  input wire LINK_UP,
  input wire LINK_GIG,
  input wire PARTNER_GIG_EEE,
  input wire PARTNER_FAST_EEE,
  input wire ACTIVITY,
  input wire REMOTE_WAKE,
  // MAC side
  input wire LPI_REQ,
  output reg MAC_OUT_EN,
  output reg MAC_FORCE_IDLE,
  output reg DATA_READY,
  // Clock selection and enables
  input wire GCLK_SEL_125,
  output reg CLK_MULT_EN,
  output reg GEN_CLK_EN,
  output reg REF_CLK_EN,
  output reg CORE_CLK_RUN,
  // Line side actions
  output reg LINE_EN,
  output reg LINK_START,
  output reg LINK_PULSE,
  output reg LPI_REFRESH,
  output reg EEE_LINK,
  output reg [5:0] POWER_STATE
);

  localparam [5:0] P_HWPD = 6'h01;
  localparam [5:0] P_SWPD = 6'h02;
  localparam [5:0] P_NORM = 6'h04;
  localparam [5:0] P_EDPD = 6'h08;
  localparam [5:0] P_LPI = 6'h10;
  localparam [5:0] P_WAKE = 6'h20;
  localparam [4:0] M_IDLE = 5'h01;
  localparam [4:0] M_HDR = 5'h02;
  localparam [4:0] M_TA = 5'h04;
  localparam [4:0] M_RD = 5'h08;
  localparam [4:0] M_WR = 5'h10;
  localparam [31:0] WAKE_GIG = `PPD_WAKE_GIG_CYC;
  localparam [31:0] WAKE_FAST = `PPD_WAKE_FAST_CYC;

  // Two-flop synchronisers for every pin input except SYS_RST and GCLK_SEL_125
  reg [13:0] sync1;
  reg [13:0] sync2;
  reg mdc_d;
  wire [13:0] pins = {REMOTE_WAKE, LPI_REQ, ACTIVITY, PARTNER_FAST_EEE,
    PARTNER_GIG_EEE, LINK_GIG, LINK_UP, LINE_ENERGY, LAMP_I, STRAP_EEE,
    STRAP_SLEEP, STRAP_SOFT_PD, MDIO_I, MDC};
  wire s_mdc = sync2[0];
  wire s_mdio = sync2[1];
  wire s_strap_soft = sync2[2];
  wire s_strap_sleep = sync2[3];
  wire s_strap_eee = sync2[4];
  wire s_lamp = sync2[5];
  wire s_energy = sync2[6];
  wire s_link = sync2[7];
  wire s_gig = sync2[8];
  wire s_p_gig = sync2[9];
  wire s_p_fast = sync2[10];
  wire s_act = sync2[11];
  wire s_lpi_req = sync2[12];
  wire s_rwake = sync2[13];
  wire mdc_rise = s_mdc & ~mdc_d;

  always @(posedge CLK)
  begin
    sync1 <= pins;
    sync2 <= sync1;
  end

  // Registers
  reg [15:0] basic_control;
  reg [15:0] phy_control_status_two;
  reg [15:0] led_control_one;
  reg [15:0] led_control_two;
  reg [15:0] led_control_three;
  reg [15:0] energy_efficient_advertise;
  reg [15:0] ext_ptr;
  reg straps_taken;
  reg lamp_active_low;

  wire soft_powerdown_bit = basic_control[`PPD_SOFT_PD_BIT];
  wire energy_detect_sleep_enable =
    phy_control_status_two[`PPD_SLEEP_EN_BIT];
  wire gigabit_efficient_advertise =
    energy_efficient_advertise[`PPD_GIG_ADV_BIT];
  wire fast_efficient_advertise =
    energy_efficient_advertise[`PPD_FAST_ADV_BIT];

  function [15:0] read_reg;
    input [15:0] adr;
    begin
      case (adr)
        `PPD_ADR_BASIC: read_reg = basic_control;
        `PPD_ADR_CTRL2: read_reg = phy_control_status_two;
        `PPD_ADR_LED1: read_reg = led_control_one;
        `PPD_ADR_LED2: read_reg = led_control_two;
        `PPD_ADR_LED3: read_reg = led_control_three;
        `PPD_ADR_EXT_PTR: read_reg = ext_ptr;
        `PPD_ADR_ENERGY_EFFICIENT_ADVERTISE: read_reg = energy_efficient_advertise;
        default: read_reg = `PPD_RST_ZERO;
      endcase
    end
  endfunction

  function [15:0] map_adr;
    input [4:0] regad;
    input [15:0] ptr;
    begin
      if ({11'h000, regad} == `PPD_ADR_EXT_DATA)
        map_adr = ptr;
      else
        map_adr = {11'h000, regad};
    end
  endfunction

  // Management frame slave
  reg [4:0] m_state;
  reg [5:0] pre_cnt;
  reg [3:0] bit_cnt;
  reg [12:0] hdr;
  reg [15:0] sh;
  reg [15:0] frame_adr;
  reg wr_go;
  reg [15:0] wr_adr;
  reg [15:0] wr_data;
  wire [12:0] hdr_full = {hdr[11:0], s_mdio};
  wire hdr_ok = hdr_full[12] & (hdr_full[9:5] == `PPD_PHY_ADDR);
  wire [15:0] hdr_adr = map_adr(hdr_full[4:0], ext_ptr);

  always @(posedge CLK)
  begin
    mdc_d <= s_mdc;
    wr_go <= 1'b0;
    if (SYS_RST)
    begin
      m_state <= M_IDLE;
      pre_cnt <= 6'h00;
      bit_cnt <= 4'h0;
      hdr <= 13'h0000;
      sh <= 16'h0000;
      frame_adr <= 16'h0000;
      wr_adr <= 16'h0000;
      wr_data <= 16'h0000;
      MDIO_O <= 1'b0;
      MDIO_OE <= 1'b0;
    end
    else if (mdc_rise)
    begin
      case (m_state)
        M_IDLE:
        begin
          if (s_mdio)
          begin
            if (pre_cnt != `PPD_PREAMBLE_LEN)
              pre_cnt <= pre_cnt + 6'h01;
          end
          else
          begin
            if (pre_cnt == `PPD_PREAMBLE_LEN)
              m_state <= M_HDR;
            pre_cnt <= 6'h00;
            bit_cnt <= 4'h0;
          end
        end
        M_HDR:
        begin
          hdr <= hdr_full;
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'hc)
          begin
            bit_cnt <= 4'h0;
            frame_adr <= hdr_adr;
            sh <= read_reg(hdr_adr);
            if (hdr_ok && (hdr_full[11:10] == `PPD_OP_READ ||
                hdr_full[11:10] == `PPD_OP_WRITE))
              m_state <= M_TA;
            else
              m_state <= M_IDLE;
          end
        end
        M_TA:
        begin
          bit_cnt <= bit_cnt + 4'h1;
          if (hdr[11:10] == `PPD_OP_READ)
          begin
            MDIO_OE <= 1'b1;
            MDIO_O <= (bit_cnt == 4'h0) ? 1'b0 : sh[15];
          end
          if (bit_cnt == 4'h1)
          begin
            bit_cnt <= 4'h0;
            m_state <= (hdr[11:10] == `PPD_OP_READ) ? M_RD : M_WR;
          end
        end
        M_RD:
        begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'hf)
          begin
            MDIO_OE <= 1'b0;
            m_state <= M_IDLE;
          end
          else
          begin
            MDIO_O <= sh[14];
            sh <= {sh[14:0], 1'b0};
          end
        end
        M_WR:
        begin
          bit_cnt <= bit_cnt + 4'h1;
          sh <= {sh[14:0], s_mdio};
          if (bit_cnt == 4'hf)
          begin
            wr_go <= 1'b1;
            wr_adr <= frame_adr;
            wr_data <= {sh[14:0], s_mdio};
            m_state <= M_IDLE;
          end
        end
        default: m_state <= M_IDLE;
      endcase
    end
  end

  // Register file with strap capture after reset release
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      basic_control <= `PPD_RST_BASIC;
      phy_control_status_two <= `PPD_RST_ZERO;
      led_control_one <= `PPD_RST_ZERO;
      led_control_two <= `PPD_RST_ZERO;
      led_control_three <= `PPD_RST_ZERO;
      energy_efficient_advertise <= `PPD_RST_ZERO;
      ext_ptr <= `PPD_RST_ZERO;
      straps_taken <= 1'b0;
      lamp_active_low <= 1'b0;
    end
    else if (!straps_taken)
    begin
      straps_taken <= 1'b1;
      basic_control[`PPD_SOFT_PD_BIT] <= s_strap_soft;
      phy_control_status_two[`PPD_SLEEP_EN_BIT] <= s_strap_sleep;
      energy_efficient_advertise[`PPD_GIG_ADV_BIT] <= s_strap_eee;
      energy_efficient_advertise[`PPD_FAST_ADV_BIT] <= s_strap_eee;
      lamp_active_low <= s_lamp;
    end
    else if (wr_go)
    begin
      case (wr_adr)
        `PPD_ADR_BASIC: basic_control <= wr_data;
        `PPD_ADR_CTRL2: phy_control_status_two <= wr_data;
        `PPD_ADR_LED1: led_control_one <= wr_data;
        `PPD_ADR_LED2: led_control_two <= wr_data;
        `PPD_ADR_LED3: led_control_three <= wr_data;
        `PPD_ADR_EXT_PTR: ext_ptr <= wr_data;
        `PPD_ADR_ENERGY_EFFICIENT_ADVERTISE: energy_efficient_advertise <= wr_data;
        default: ext_ptr <= ext_ptr;
      endcase
    end
  end

  // Power mode machine
  reg [5:0] state;
  reg [5:0] next_state;
  reg [31:0] timer;
  wire efficient_link = s_link & (s_gig ?
    (gigabit_efficient_advertise & s_p_gig) :
    (fast_efficient_advertise & s_p_fast));
  wire line_busy = (s_energy | s_link) & ~soft_powerdown_bit;
  wire [31:0] wake_cyc = s_gig ? WAKE_GIG : WAKE_FAST;

  always @*
  begin
    next_state = state;
    case (state)
      P_HWPD:
        if (!straps_taken)
          next_state = s_strap_soft ? P_SWPD : P_NORM;
      P_SWPD:
        if (!soft_powerdown_bit)
          next_state = P_NORM;
      P_NORM:
        if (efficient_link && s_lpi_req)
          next_state = P_LPI;
        else if (energy_detect_sleep_enable && !line_busy &&
            timer >= SILENCE_CYC - 32'h1)
          next_state = P_EDPD;
      P_EDPD:
        if (s_energy)
          next_state = P_NORM;
      P_LPI:
        if (!s_lpi_req || s_rwake || !efficient_link)
          next_state = P_WAKE;
      P_WAKE:
        if (timer >= wake_cyc - 32'h1)
          next_state = P_NORM;
      default: next_state = P_HWPD;
    endcase
    if (soft_powerdown_bit && straps_taken && state != P_HWPD)
      next_state = P_SWPD;
  end

  wire nx_low = next_state == P_SWPD || next_state == P_EDPD ||
    next_state == P_LPI;
  wire nx_run = next_state == P_NORM || next_state == P_WAKE;

  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      state <= P_HWPD;
      timer <= 32'h0;
      MAC_OUT_EN <= 1'b0;
      MAC_FORCE_IDLE <= 1'b0;
      DATA_READY <= 1'b0;
      CLK_MULT_EN <= 1'b0;
      GEN_CLK_EN <= 1'b0;
      REF_CLK_EN <= 1'b0;
      CORE_CLK_RUN <= 1'b0;
      LINE_EN <= 1'b0;
      LINK_START <= 1'b0;
      LINK_PULSE <= 1'b0;
      LPI_REFRESH <= 1'b0;
      EEE_LINK <= 1'b0;
      POWER_STATE <= P_HWPD;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        timer <= 32'h0;
      else if (state == P_NORM && line_busy)
        timer <= 32'h0;
      else if (state == P_EDPD && timer >= PULSE_CYC - 32'h1)
        timer <= 32'h0;
      else if (state == P_LPI && timer >= REFRESH_CYC - 32'h1)
        timer <= 32'h0;
      else if (timer != 32'hffffffff)
        timer <= timer + 32'h1;
      MAC_OUT_EN <= 1'b1;
      MAC_FORCE_IDLE <= next_state == P_SWPD;
      DATA_READY <= next_state == P_NORM;
      CLK_MULT_EN <= nx_run | (nx_low & GCLK_SEL_125);
      GEN_CLK_EN <= 1'b1;
      REF_CLK_EN <= 1'b1;
      CORE_CLK_RUN <= nx_run;
      LINE_EN <= next_state != P_SWPD;
      LINK_START <= next_state == P_NORM &&
        (state == P_SWPD || state == P_EDPD || state == P_HWPD);
      LINK_PULSE <= (state == P_EDPD && next_state == P_EDPD &&
        timer >= PULSE_CYC - 32'h1) ||
        (state == P_EDPD && next_state == P_NORM);
      LPI_REFRESH <= state == P_LPI && next_state == P_LPI &&
        timer >= REFRESH_CYC - 32'h1;
      EEE_LINK <= efficient_link;
      POWER_STATE <= next_state;
    end
  end

  // Status lamp
  reg [31:0] blink_cnt;
  reg blink_phase;
  wire lamp_on = led_control_one[`PPD_LED_OVR_BIT] ?
    led_control_one[`PPD_LED_ON_BIT] :
    (s_link & (~s_act | blink_phase));

  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      blink_cnt <= 32'h0;
      blink_phase <= 1'b0;
      LAMP_O <= 1'b0;
      LAMP_OE <= 1'b0;
    end
    else
    begin
      if (blink_cnt >= BLINK_CYC - 32'h1)
      begin
        blink_cnt <= 32'h0;
        blink_phase <= ~blink_phase;
      end
      else
        blink_cnt <= blink_cnt + 32'h1;
      LAMP_OE <= straps_taken;
      LAMP_O <= lamp_on ^ lamp_active_low;
    end
  end

endmodule // ppd_power_ctrl
`default_nettype wire

// file: logic/ppd_power_ctrl_end.v
`timescale 1ns/100ps
`default_nettype none
// Holds no logic; the whole controller lives in ppd_power_ctrl.v
`default_nettype wire

// file: logic/ppd_power_map.vh
// Register map, field positions, reset values and timing for the power controller
// Assumes a 100 MHz system clock and a clause 22 style management frame
`ifndef PPD_POWER_MAP_VH
`define PPD_POWER_MAP_VH
// Clock rate
`define PPD_CLK_MHZ 100
`define PPD_CLK_KHZ 100000
// Management addresses
`define PPD_PHY_ADDR 5'h00
`define PPD_ADR_BASIC 16'h0000
`define PPD_ADR_CTRL2 16'h0015
`define PPD_ADR_LED1 16'h001b
`define PPD_ADR_LED2 16'h001c
`define PPD_ADR_LED3 16'h001d
`define PPD_ADR_EXT_PTR 16'h0010
`define PPD_ADR_EXT_DATA 16'h0011
`define PPD_ADR_ENERGY_EFFICIENT_ADVERTISE 16'h8001
// Field positions
`define PPD_SOFT_PD_BIT 11
`define PPD_SLEEP_EN_BIT 3
`define PPD_GIG_ADV_BIT 2
`define PPD_FAST_ADV_BIT 1
`define PPD_LED_OVR_BIT 0
`define PPD_LED_ON_BIT 1
// Reset values
`define PPD_RST_BASIC 16'h1140
`define PPD_RST_ZERO 16'h0000
// Frame opcodes
`define PPD_OP_READ 2'h2
`define PPD_OP_WRITE 2'h1
`define PPD_PREAMBLE_LEN 6'h20
// Timing in printed units
`define PPD_WAKE_GIG_US 16
`define PPD_WAKE_FAST_US 20
`define PPD_SILENCE_MS 3000
`define PPD_PULSE_MS 1000
`define PPD_REFRESH_MS 20
`define PPD_BLINK_MS 50
// Derived cycle counts
`define PPD_WAKE_GIG_CYC (`PPD_WAKE_GIG_US * `PPD_CLK_MHZ)
`define PPD_WAKE_FAST_CYC (`PPD_WAKE_FAST_US * `PPD_CLK_MHZ)
`define PPD_SILENCE_CYC (`PPD_SILENCE_MS * `PPD_CLK_KHZ)
`define PPD_PULSE_CYC (`PPD_PULSE_MS * `PPD_CLK_KHZ)
`define PPD_REFRESH_CYC (`PPD_REFRESH_MS * `PPD_CLK_KHZ)
`define PPD_BLINK_CYC (`PPD_BLINK_MS * `PPD_CLK_KHZ)
`endif

// file: verif/ppd_mac_model.sv
// MAC side model: asks for low power idle, shows MAC pin levels
// Pins released by the PHY fall to the weak pull-downs
`timescale 1ns/100ps
`default_nettype none
module ppd_mac_model
(
  // Clock
  input wire logic clk,
  // PHY side
  input wire logic mac_out_en,
  input wire logic force_idle,
  input wire logic data_ready,
  output logic lpi_req,
  // Bench control and pin view
  input wire logic want_idle,
  output logic rxc_pin
);
  // Idle asked only once data can flow, held while idle is wanted
  always @(negedge clk)
    lpi_req <= want_idle && (data_ready || lpi_req);
  // Receive clock: pulled low, fixed high in idle, else running
  assign rxc_pin = mac_out_en && (force_idle || clk);
endmodule // ppd_mac_model
`default_nettype wire

// file: verif/ppd_power_ctrl_monitor.sv
// Checker for the power controller top-level ports
// Bound to ppd_power_ctrl; one clock, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module ppd_power_ctrl_monitor
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Watched inputs
  input wire logic GCLK_SEL_125,
  // Watched outputs
  input wire logic MDIO_OE,
  input wire logic MAC_OUT_EN,
  input wire logic MAC_FORCE_IDLE,
  input wire logic DATA_READY,
  input wire logic CLK_MULT_EN,
  input wire logic GEN_CLK_EN,
  input wire logic REF_CLK_EN,
  input wire logic LINE_EN,
  input wire logic LINK_START,
  input wire logic LPI_REFRESH,
  input wire logic EEE_LINK,
  input wire logic [5:0] POWER_STATE
);
  logic [11:0] wake_cnt;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  // Cycles spent in the wake state
  always_ff @(posedge CLK)
    if (SYS_RST || POWER_STATE != 6'h20)
      wake_cnt <= 12'h000;
    else
      wake_cnt <= wake_cnt + 12'h001;
  a_reset_off: assert property (disable iff (1'b0)
    SYS_RST |=> POWER_STATE == 6'h01 && !MAC_OUT_EN && !CLK_MULT_EN
    && !GEN_CLK_EN && !REF_CLK_EN) else $error("reset state wrong");
  a_reset_quiet: assert property (disable iff (1'b0)
    SYS_RST |=> !MDIO_OE) else $error("management answered in reset");
  a_soft_idle: assert property (
    POWER_STATE == 6'h02 && $stable(POWER_STATE)
    |-> MAC_FORCE_IDLE && !LINE_EN && !DATA_READY)
    else $error("soft power-down pins wrong");
  a_mult_low: assert property (
    (POWER_STATE[1] || POWER_STATE[3] || POWER_STATE[4])
    && $stable(POWER_STATE) && $stable(GCLK_SEL_125)
    |-> CLK_MULT_EN == GCLK_SEL_125) else $error("multiplier wrong");
  a_start_once: assert property (
    LINK_START |-> POWER_STATE == 6'h04 ##1 !LINK_START)
    else $error("link start pulse wrong");
  a_ready_norm: assert property (
    DATA_READY |-> POWER_STATE == 6'h04) else $error("data ready early");
  a_lpi_entry: assert property (
    $rose(POWER_STATE == 6'h10) |-> EEE_LINK)
    else $error("idle without efficient link");
  a_wake_bound: assert property (
    wake_cnt <= 12'h7d0) else $error("wake too long");
  a_refresh_lpi: assert property (
    LPI_REFRESH |-> POWER_STATE == 6'h10) else $error("refresh outside idle");
  c_lpi: cover property ($rose(POWER_STATE == 6'h10));
  c_sleep: cover property ($rose(POWER_STATE == 6'h08));
  c_wake: cover property ($fell(POWER_STATE == 6'h20));
endmodule // ppd_power_ctrl_monitor
`default_nettype wire

// file: verif/ppd_power_ctrl_tb.sv
// Self-checking bench for the power controller
// Pins change on the falling edge; MDIO is pulled up when released
`timescale 1ns/100ps
`default_nettype none
module ppd_power_ctrl_tb;
  logic CLK, SYS_RST, MDC, MDIO_O, MDIO_OE, LAMP_O, LAMP_OE, LPI_REQ;
  logic STRAP_SOFT_PD, STRAP_SLEEP, STRAP_EEE, LAMP_I, LINE_ENERGY;
  logic LINK_UP, LINK_GIG, PARTNER_GIG_EEE, PARTNER_FAST_EEE, ACTIVITY;
  logic REMOTE_WAKE, GCLK_SEL_125, MAC_OUT_EN, MAC_FORCE_IDLE, DATA_READY;
  logic CLK_MULT_EN, GEN_CLK_EN, REF_CLK_EN, CORE_CLK_RUN, LINE_EN;
  logic LINK_START, LINK_PULSE, LPI_REFRESH, EEE_LINK, tb_oe, tb_bit;
  logic want_idle, rxc_pin;
  logic [5:0] POWER_STATE;
  wire logic MDIO_I;
  int mismatches, check_count, starts, pulses, refs, wakes, n, e, s0, w0;
  assign MDIO_I = MDIO_OE ? MDIO_O : (tb_oe ? tb_bit : 1'b1);
  ppd_power_ctrl #(.SILENCE_CYC(32'd50), .PULSE_CYC(32'd20),
    .REFRESH_CYC(32'd10), .BLINK_CYC(32'd4)) ppd_power_ctrl_i (.*);
  ppd_mac_model ppd_mac_model_i (.clk(CLK), .mac_out_en(MAC_OUT_EN),
    .force_idle(MAC_FORCE_IDLE), .data_ready(DATA_READY),
    .lpi_req(LPI_REQ), .want_idle(want_idle), .rxc_pin(rxc_pin));
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // Pulse and state counters
  always @(posedge CLK)
  begin
    starts <= starts + (LINK_START === 1'b1);
    pulses <= pulses + (LINK_PULSE === 1'b1);
    refs <= refs + (LPI_REFRESH === 1'b1);
    wakes <= wakes + (POWER_STATE === 6'h20);
  end
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: bit %b not %b", $time, got, exp);
    end
  endtask
  task chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task tick(input int c);
    repeat (c) @(negedge CLK);
  endtask
  task mdc_bit(input logic b, input logic drv);
    tb_oe = drv;
    tb_bit = b;
    MDC = 1'b0;
    tick(8);
    MDC = 1'b1;
    tick(8);
  endtask
  task frame(input logic [1:0] op, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    hdr = {32'hffffffff, 2'b01, op, 5'h00, ra};
    for (int i = 45; i >= 0; i--)
      mdc_bit(hdr[i], 1'b1);
    for (int i = 17; i >= 0; i--)
    begin
      mdc_bit(i == 17 ? 1'b1 : (i == 16 ? 1'b0 : wd[i]), op == 2'h1);
      if (i >= 1 && i <= 16)
        rd[i - 1] = MDIO_I;
    end
    tb_oe = 1'b0;
  endtask
  task wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    frame(2'h1, ra, d, x);
  endtask
  task rd_chk(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] x;
    frame(2'h2, ra, 16'h0000, x);
    chk_word(x, exp);
  endtask
  task wait_st(input logic [5:0] s);
    for (int i = 0; i < 4000 && POWER_STATE !== s; i++)
      tick(1);
    chk_word({10'h000, POWER_STATE}, {10'h000, s});
  endtask
  initial
  begin
    {MDC, tb_oe, tb_bit, want_idle, STRAP_SLEEP, STRAP_EEE} = '0;
    {LINE_ENERGY, LINK_UP, LINK_GIG, PARTNER_GIG_EEE, ACTIVITY} = '0;
    {PARTNER_FAST_EEE, REMOTE_WAKE, GCLK_SEL_125} = '0;
    {SYS_RST, STRAP_SOFT_PD, LAMP_I} = 3'h7;
    tick(4);
    chk_word({10'h000, POWER_STATE}, 16'h0001);
    chk_bit(MAC_OUT_EN | REF_CLK_EN | GEN_CLK_EN, 1'b0);
    SYS_RST = 1'b0;
    wait_st(6'h02);
    tick(3);
    chk_bit(MAC_FORCE_IDLE & ~LINE_EN, 1'b1);
    chk_bit(rxc_pin, 1'b1);
    chk_bit(CLK_MULT_EN, 1'b0);
    chk_bit(GEN_CLK_EN & REF_CLK_EN & ~CORE_CLK_RUN, 1'b1);
    rd_chk(5'h00, 16'h1940);
    rd_chk(5'h05, 16'h0000);
    GCLK_SEL_125 = 1'b1;
    LINE_ENERGY = 1'b1;
    tick(60);
    chk_bit(CLK_MULT_EN, 1'b1);
    chk_word({10'h000, POWER_STATE}, 16'h0002);
    GCLK_SEL_125 = 1'b0;
    LINK_UP = 1'b1;
    wr(5'h00, 16'h1140);
    wait_st(6'h04);
    tick(2);
    chk_word(starts[15:0], 16'h0001);
    chk_bit(CORE_CLK_RUN & CLK_MULT_EN & MAC_OUT_EN, 1'b1);
    chk_bit(LAMP_O === 1'b0 && LAMP_OE === 1'b1, 1'b1);
    ACTIVITY = 1'b1;
    n = 0;
    repeat (20)
    begin
      tick(1);
      n += (LAMP_O === 1'b1);
    end
    chk_bit(n > 0 && n < 20, 1'b1);
    ACTIVITY = 1'b0;
    wr(5'h1b, 16'h0001);
    chk_bit(LAMP_O, 1'b1);
    wr(5'h1b, 16'h0003);
    chk_bit(LAMP_O, 1'b0);
    wr(5'h1c, 16'h00a5);
    rd_chk(5'h1c, 16'h00a5);
    LINK_GIG = 1'b1;
    PARTNER_GIG_EEE = 1'b1;
    PARTNER_FAST_EEE = 1'b1;
    wr(5'h10, 16'h8001);
    wr(5'h11, 16'h0004);
    chk_bit(EEE_LINK, 1'b1);
    LINK_GIG = 1'b0;
    want_idle = 1'b1;
    tick(30);
    chk_bit(EEE_LINK, 1'b0);
    chk_word({10'h000, POWER_STATE}, 16'h0004);
    for (int k = 0; k < 2; k++)
    begin
      want_idle = 1'b0;
      LINK_GIG = (k == 0);
      wr(5'h11, k == 0 ? 16'h0004 : 16'h0002);
      want_idle = 1'b1;
      wait_st(6'h10);
      s0 = refs;
      tick(40);
      chk_bit(refs - s0 >= 3 && DATA_READY === 1'b0, 1'b1);
      w0 = wakes;
      e = k == 0 ? 1600 : 2000;
      want_idle = (k == 1);
      REMOTE_WAKE = (k == 1);
      wait_st(6'h20);
      want_idle = 1'b0;
      REMOTE_WAKE = 1'b0;
      wait_st(6'h04);
      chk_bit(wakes - w0 >= e - 1 && wakes - w0 <= e + 1, 1'b1);
    end
    LINK_UP = 1'b0;
    LINE_ENERGY = 1'b0;
    tick(100);
    chk_word({10'h000, POWER_STATE}, 16'h0004);
    wr(5'h15, 16'h0008);
    wait_st(6'h08);
    s0 = pulses;
    tick(70);
    chk_bit(pulses - s0 >= 3, 1'b1);
    s0 = starts;
    LINE_ENERGY = 1'b1;
    wait_st(6'h04);
    tick(2);
    chk_bit(starts - s0 == 1, 1'b1);
    {STRAP_SOFT_PD, LAMP_I, SYS_RST} = 3'h1;
    rd_chk(5'h00, 16'hffff);
    chk_word({10'h000, POWER_STATE}, 16'h0001);
    SYS_RST = 1'b0;
    LINK_UP = 1'b1;
    wait_st(6'h04);
    tick(4);
    chk_bit(LAMP_O, 1'b1);
    rd_chk(5'h00, 16'h1140);
    rd_chk(5'h15, 16'h0000);
    finish_test;
  end
  initial
  begin
    #600000;
    mismatches++;
    finish_test;
  end
endmodule // ppd_power_ctrl_tb
bind ppd_power_ctrl ppd_power_ctrl_monitor ppd_power_ctrl_monitor_i (.*);
`default_nettype wire
